// >>> hwmfc_core.sv
`timescale 1ns/1ps
module hwmfc_core
	import hwmfc_pkg::*;
#(
	parameter int BOOST_TICK = BOOST_TICK_CYC,
	parameter int LUT_DEPTH  = 16
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [7:0]   reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic      [7:0]   reg_rdata_o,
	input  hwmfc_sense_s      sense_i,
	input  wire logic [6:0]   voltage_identification_inputs_i,
	input  wire logic         ext_error_input_a_i,
	input  wire logic         ext_error_input_b_i,
	input  wire logic [3:0]   tach_err_i,
	output logic      [1:0]   pwm_oe_o,
	output logic              alert_oe_o
);

	localparam int LAW = $clog2(LUT_DEPTH);

	logic [7:0]                 cfg_reg;
	logic [7:0]                 window_reg;
	logic [7:0]                 alert_mask_reg;
	logic [7:0]                 temp_limit_reg;
	logic [7:0]                 pi_target_reg;
	logic [7:0]                 pi_gain_reg;
	logic [7:0]                 boost_time_reg;
	logic [4:0]                 mgmt_stat_reg;
	logic [4:0]                 host_stat_reg;
	logic [4:0]                 mgmt_stat_next;
	logic [4:0]                 host_stat_next;
	logic [N_TEMP-1:0][8:0]     unf_reg;
	logic [N_FILT-1:0][11:0]    filt_reg;
	logic [N_VOLT-1:0][7:0]     volt_reg;
	logic [7:0]                 vid_expect_reg;
	logic                       vccp_fault_reg;
	logic [1:0][7:0]            lut_duty_reg;
	logic [1:0][7:0]            pi_integ_reg;
	logic [1:0][7:0]            duty_reg;
	logic [7:0]                 boost_timer_reg;
	logic                       lut_sel_reg;
	logic [7:0]                 pwm_cnt_reg;
	logic [15:0]                step_div_reg;
	logic [15:0]                boost_div_reg;
	logic [3:0]                 pi_div_reg;
	logic                       step_en;
	logic                       boost_tick;
	logic                       pi_tick;
	logic [4:0]                 events;
	logic                       temp_hi;
	logic                       ext_armed;
	logic [LAW-1:0]             lut_raddr;
	logic [7:0]                 lut_rdata;
	logic [7:0]                 rd_value;
	logic [1:0][7:0]            demand;
	logic [1:0]                 boost_on;

	function automatic logic [LAW-1:0] lut_index(input logic [11:0] f);
		if (f[11]) begin
			return '0;
		end else if (f[10:7] > 4'(LUT_DEPTH - 1)) begin
			return LAW'(LUT_DEPTH - 1);
		end
		return LAW'(f[10:7]);
	endfunction

	function automatic logic signed [11:0] temp_err(input logic [11:0] f, input logic [7:0] tgt);
		return $signed({{4{f[11]}}, f[11:4]}) - $signed({4'h0, tgt});
	endfunction

	// Slow rates come from single-cycle enable pulses.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_div_reg  <= '0;
			boost_div_reg <= '0;
			pi_div_reg    <= '0;
		end else begin
			step_div_reg  <= step_en ? '0 : step_div_reg + 16'h0001;
			boost_div_reg <= boost_tick ? '0 : boost_div_reg + 16'h0001;
			if (boost_tick) begin
				pi_div_reg <= pi_div_reg + 4'h1;
			end
		end
	end

	assign step_en    = (step_div_reg == 16'(PWM_STEP_CYC - 1));
	assign boost_tick = (boost_div_reg == 16'(BOOST_TICK - 1));
	assign pi_tick    = boost_tick && (pi_div_reg == 4'(PI_TICK_DIV - 1));

	// Converted samples are captured in their reported formats.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unf_reg  <= '0;
			filt_reg <= '0;
			volt_reg <= '0;
		end else if (sense_i.sample) begin
			for (int i = 0; i < N_TEMP; i++) begin
				unf_reg[i] <= sense_i.temp[i][11:3];
			end
			for (int i = 0; i < N_FILT; i++) begin
				filt_reg[i] <= filt_reg[i] + 12'(($signed({sense_i.temp[i][11], sense_i.temp[i]})
					- $signed({filt_reg[i][11], filt_reg[i]})) >>> 2);
			end
			volt_reg <= sense_i.volt;
		end
	end

	// The regulator reading is compared against a window around the decoded level.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vid_expect_reg <= '0;
			vccp_fault_reg <= 1'b0;
		end else begin
			vid_expect_reg <= hwmfc_vid_decode(cfg_reg[CFG_SCHEME_LO +: 2],
				voltage_identification_inputs_i);
			vccp_fault_reg <= ({1'b0, volt_reg[VCCP_CH]} + {1'b0, window_reg} < {1'b0, vid_expect_reg})
				|| ({1'b0, volt_reg[VCCP_CH]} > {1'b0, vid_expect_reg} + {1'b0, window_reg});
		end
	end

	always_comb begin
		temp_hi = 1'b0;
		for (int i = 0; i < N_TEMP; i++) begin
			if (!unf_reg[i][8] && (unf_reg[i][8:1] > temp_limit_reg)) begin
				temp_hi = 1'b1;
			end
		end
	end

	assign ext_armed = (cfg_reg[CFG_SCHEME_LO +: 2] == HWMFC_VID_BASE);
	assign events = {ext_armed & ext_error_input_b_i, ext_armed & ext_error_input_a_i,
		|tach_err_i, vccp_fault_reg, temp_hi};

	// Each status set clears on its own writes; a new event wins over a clear.
	always_comb begin
		mgmt_stat_next = mgmt_stat_reg;
		host_stat_next = host_stat_reg;
		if (reg_wr_i && reg_addr_i == ADDR_MGMT_STAT) begin
			mgmt_stat_next = mgmt_stat_reg & ~reg_wdata_i[4:0];
		end
		if (reg_wr_i && reg_addr_i == ADDR_HOST_STAT) begin
			host_stat_next = host_stat_reg & ~reg_wdata_i[4:0];
		end
		mgmt_stat_next = mgmt_stat_next | events;
		host_stat_next = host_stat_next | events;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mgmt_stat_reg <= '0;
			host_stat_reg <= '0;
		end else begin
			mgmt_stat_reg <= mgmt_stat_next;
			host_stat_reg <= host_stat_next;
		end
	end

	// Alert pulls the line low while asserted.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alert_oe_o <= 1'b0;
		end else if (cfg_reg[CFG_ALERT_CMP]) begin
			alert_oe_o <= |(events & ST_THERMAL & alert_mask_reg[4:0]);
		end else begin
			alert_oe_o <= |(host_stat_reg & alert_mask_reg[4:0]);
		end
	end

	// Configuration registers written from the host port.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_reg        <= RST_CFG;
			window_reg     <= RST_WINDOW;
			alert_mask_reg <= RST_ALERT_MASK;
			temp_limit_reg <= RST_TEMP_LIMIT;
			pi_target_reg  <= RST_PI_TARGET;
			pi_gain_reg    <= RST_PI_GAIN;
			boost_time_reg <= RST_BOOST_TIME;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_CFG:        cfg_reg        <= reg_wdata_i;
				ADDR_WINDOW:     window_reg     <= reg_wdata_i;
				ADDR_ALERT_MASK: alert_mask_reg <= reg_wdata_i;
				ADDR_TEMP_LIMIT: temp_limit_reg <= reg_wdata_i;
				ADDR_PI_TARGET:  pi_target_reg  <= reg_wdata_i;
				ADDR_PI_GAIN:    pi_gain_reg    <= reg_wdata_i;
				ADDR_BOOST_TIME: boost_time_reg <= reg_wdata_i;
				default:         cfg_reg        <= cfg_reg;
			endcase
		end
	end

	// Read data appear in the cycle after the read strobe.
	always_comb begin
		rd_value = 8'h00;
		for (int i = 0; i < N_FILT; i++) begin
			if (reg_addr_i == ADDR_TEMP_BASE + 8'(2 * i)) begin
				rd_value = {unf_reg[i][0], 7'h00};
			end
			if (reg_addr_i == ADDR_TEMP_BASE + 8'(2 * i + 1)) begin
				rd_value = unf_reg[i][8:1];
			end
			if (reg_addr_i == ADDR_FILT_BASE + 8'(2 * i)) begin
				rd_value = {filt_reg[i][3:0], 4'h0};
			end
			if (reg_addr_i == ADDR_FILT_BASE + 8'(2 * i + 1)) begin
				rd_value = filt_reg[i][11:4];
			end
		end
		for (int i = 0; i < N_VOLT; i++) begin
			if (reg_addr_i == ADDR_VOLT_BASE + 8'(i)) begin
				rd_value = volt_reg[i];
			end
		end
		case (reg_addr_i)
			ADDR_INT_TEMP:          rd_value = {unf_reg[N_TEMP-1][0], 7'h00};
			ADDR_INT_TEMP + 8'h01:  rd_value = unf_reg[N_TEMP-1][8:1];
			ADDR_PWM1_DUTY:         rd_value = duty_reg[0];
			ADDR_PWM2_DUTY:         rd_value = duty_reg[1];
			ADDR_CFG:               rd_value = cfg_reg;
			ADDR_WINDOW:            rd_value = window_reg;
			ADDR_ALERT_MASK:        rd_value = alert_mask_reg;
			ADDR_MGMT_STAT:         rd_value = {3'h0, mgmt_stat_reg};
			ADDR_HOST_STAT:         rd_value = {3'h0, host_stat_reg};
			ADDR_TEMP_LIMIT:        rd_value = temp_limit_reg;
			ADDR_PI_TARGET:         rd_value = pi_target_reg;
			ADDR_PI_GAIN:           rd_value = pi_gain_reg;
			ADDR_BOOST_TIME:        rd_value = boost_time_reg;
			ADDR_VID_EXPECT:        rd_value = vid_expect_reg;
			default:                rd_value = rd_value;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_value;
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// The duty table is read for the two outputs on alternate cycles.
	assign lut_raddr = lut_index(filt_reg[lut_sel_reg ? 1 : 0]);

	hwmfc_lut_mem #(
		.WIDTH (8),
		.DEPTH (LUT_DEPTH)
	) u_lut (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (reg_wr_i && reg_addr_i[7:4] == ADDR_LUT_BASE[7:4]),
		.waddr_i   (reg_addr_i[LAW-1:0]),
		.wdata_i   (reg_wdata_i),
		.raddr_i   (lut_raddr),
		.rdata_o   (lut_rdata)
	);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lut_sel_reg  <= 1'b0;
			lut_duty_reg <= '0;
		end else begin
			lut_sel_reg <= ~lut_sel_reg;
			lut_duty_reg[~lut_sel_reg] <= lut_rdata;
		end
	end

	// Integral term walks one step every 16th slow tick toward the target.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pi_integ_reg <= '0;
		end else if (pi_tick) begin
			for (int c = 0; c < 2; c++) begin
				if (temp_err(filt_reg[c], pi_target_reg) > 12'sh000 && pi_integ_reg[c] != 8'hff) begin
					pi_integ_reg[c] <= pi_integ_reg[c] + 8'h01;
				end else if (temp_err(filt_reg[c], pi_target_reg) < 12'sh000
					&& pi_integ_reg[c] != 8'h00) begin
					pi_integ_reg[c] <= pi_integ_reg[c] - 8'h01;
				end
			end
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			demand[c] = hwmfc_sat8(12'(temp_err(filt_reg[c], pi_target_reg)
				* $signed({1'b0, pi_gain_reg[3:0]})) + $signed({4'h0, pi_integ_reg[c]}));
			if (lut_duty_reg[c] > demand[c]) begin
				demand[c] = lut_duty_reg[c];
			end
		end
	end

	// Tach errors reload the minimum boost time; it counts down on the slow tick.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boost_timer_reg <= '0;
		end else if (|tach_err_i) begin
			boost_timer_reg <= boost_time_reg;
		end else if (boost_tick && boost_timer_reg != 8'h00) begin
			boost_timer_reg <= boost_timer_reg - 8'h01;
		end
	end

	assign boost_on[0] = cfg_reg[CFG_BOOST1]
		&& (temp_hi || (|tach_err_i) || boost_timer_reg != 8'h00);
	assign boost_on[1] = cfg_reg[CFG_BOOST2]
		&& (temp_hi || (|tach_err_i) || boost_timer_reg != 8'h00);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_reg <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				duty_reg[c] <= boost_on[c] ? DUTY_FULL : demand[c];
			end
		end
	end

	// Open-drain fan outputs pull low for the off part of each period.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_cnt_reg <= '0;
			pwm_oe_o    <= 2'h3;
		end else begin
			if (step_en) begin
				pwm_cnt_reg <= (pwm_cnt_reg == 8'hfe) ? 8'h00 : pwm_cnt_reg + 8'h01;
			end
			for (int c = 0; c < 2; c++) begin
				pwm_oe_o[c] <= !(duty_reg[c] == DUTY_FULL || pwm_cnt_reg < duty_reg[c]);
			end
		end
	end

endmodule

// >>> hwmfc_core_chk.sv
`timescale 1ns/1ps
module hwmfc_core_chk
	import hwmfc_pkg::*;
#(
	parameter int BOOST_TICK = 8,
	parameter int LUT_DEPTH  = 16
) (
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input hwmfc_sense_s    sense_i,
	input wire logic [6:0] voltage_identification_inputs_i,
	input wire logic       ext_error_input_a_i,
	input wire logic       ext_error_input_b_i,
	input wire logic [3:0] tach_err_i,
	input wire logic [1:0] pwm_oe_o,
	input wire logic       alert_oe_o
);
	logic [7:0] cfg_sh;
	logic [7:0] mask_sh;
	logic [7:0] bt_sh;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Shadow copies of the cfg, alert mask and boost time registers, tracked from the write strobe.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_sh <= RST_CFG;
		end else if (reg_wr_i && reg_addr_i == ADDR_CFG) begin
			cfg_sh <= reg_wdata_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_sh <= RST_ALERT_MASK;
		end else if (reg_wr_i && reg_addr_i == ADDR_ALERT_MASK) begin
			mask_sh <= reg_wdata_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bt_sh <= RST_BOOST_TIME;
		end else if (reg_wr_i && reg_addr_i == ADDR_BOOST_TIME) begin
			bt_sh <= reg_wdata_i;
		end
	end

	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside the answer cycle");
	a_unmapped_read: assert property (reg_rd_i && reg_addr_i == 8'hff |=> reg_rdata_o == 8'h00)
		else $error("unmapped read returned nonzero data");
	a_boost_entry: assert property (cfg_sh[CFG_BOOST1] && tach_err_i != 4'h0
		|-> ##[1:3] !pwm_oe_o[0]) else $error("fan 1 not released on tach boost");
	a_boost_hold: assert property ($fell(tach_err_i != 4'h0) && $past(tach_err_i != 4'h0, 4)
		&& cfg_sh[CFG_BOOST1] && bt_sh >= 8'h02 |-> (!pwm_oe_o[0]) [*8])
		else $error("tach boost ended too early");
	a_alert_masked: assert property (!cfg_sh[CFG_ALERT_CMP] && mask_sh[4:0] == 5'h00
		|=> !alert_oe_o) else $error("alert raised with all events masked");
	a_alert_ext: assert property (!cfg_sh[CFG_ALERT_CMP] && cfg_sh[1:0] == 2'h0
		&& mask_sh[ST_EXT_A] && ext_error_input_a_i |-> ##[1:3] alert_oe_o)
		else $error("external error did not raise alert");
	a_cmp_nontherm: assert property (cfg_sh[CFG_ALERT_CMP] && !mask_sh[ST_TEMP_HI]
		|=> !alert_oe_o) else $error("comparator alert without thermal cause");
	a_int_latch: assert property (!cfg_sh[CFG_ALERT_CMP] && alert_oe_o && !reg_wr_i
		&& !$past(reg_wr_i) |=> alert_oe_o) else $error("latched alert dropped without clear");

	c_boost: cover property (cfg_sh[CFG_BOOST1] && tach_err_i != 4'h0);
	c_cmp_alert: cover property (cfg_sh[CFG_ALERT_CMP] && alert_oe_o);
	c_int_alert: cover property (!cfg_sh[CFG_ALERT_CMP] && alert_oe_o);
endmodule

bind hwmfc_core hwmfc_core_chk #(.BOOST_TICK(BOOST_TICK), .LUT_DEPTH(LUT_DEPTH)) i_hwmfc_core_chk (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .sense_i(sense_i),
	.voltage_identification_inputs_i(voltage_identification_inputs_i),
	.ext_error_input_a_i(ext_error_input_a_i), .ext_error_input_b_i(ext_error_input_b_i),
	.tach_err_i(tach_err_i), .pwm_oe_o(pwm_oe_o), .alert_oe_o(alert_oe_o));

// >>> hwmfc_host_model.sv
`timescale 1ns/1ps
module hwmfc_host_model (
	input  wire logic       ref_clk_i,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	input  wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
	end

	// Released lines show the inverse so stale values are never mistaken for data.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		@(negedge ref_clk_i);
		d = reg_rdata_i;
	endtask
endmodule

// >>> hwmfc_lut_mem.sv
`timescale 1ns/1ps
module hwmfc_lut_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             wr_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk_i) begin
		if (wr_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

// >>> hwmfc_pkg.sv
package hwmfc_pkg;

	localparam int CLK_HZ        = 40_000_000;
	localparam int PWM_STEP_NS   = 100;
	localparam int PWM_STEP_CYC  = (PWM_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int BOOST_TICK_US = 1000;
	localparam int BOOST_TICK_CYC = BOOST_TICK_US * (CLK_HZ / 1_000_000);
	localparam int PI_TICK_DIV   = 16;

	localparam int N_TEMP  = 5;
	localparam int N_FILT  = 4;
	localparam int N_VOLT  = 9;
	localparam int VCCP_CH = 0;

	localparam logic [7:0] ADDR_PWM1_DUTY  = 8'h0a;
	localparam logic [7:0] ADDR_PWM2_DUTY  = 8'h0b;
	localparam logic [7:0] ADDR_TEMP_BASE  = 8'h10;
	localparam logic [7:0] ADDR_FILT_BASE  = 8'h18;
	localparam logic [7:0] ADDR_INT_TEMP   = 8'h20;
	localparam logic [7:0] ADDR_CFG        = 8'h40;
	localparam logic [7:0] ADDR_WINDOW     = 8'h41;
	localparam logic [7:0] ADDR_ALERT_MASK = 8'h42;
	localparam logic [7:0] ADDR_MGMT_STAT  = 8'h43;
	localparam logic [7:0] ADDR_HOST_STAT  = 8'h44;
	localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h45;
	localparam logic [7:0] ADDR_PI_TARGET  = 8'h46;
	localparam logic [7:0] ADDR_PI_GAIN    = 8'h47;
	localparam logic [7:0] ADDR_BOOST_TIME = 8'h48;
	localparam logic [7:0] ADDR_VID_EXPECT = 8'h49;
	localparam logic [7:0] ADDR_LUT_BASE   = 8'h50;
	localparam logic [7:0] ADDR_VOLT_BASE  = 8'h60;

	localparam int CFG_SCHEME_LO = 0;
	localparam int CFG_ALERT_CMP = 2;
	localparam int CFG_BOOST1    = 3;
	localparam int CFG_BOOST2    = 4;

	localparam int ST_TEMP_HI = 0;
	localparam int ST_VCCP    = 1;
	localparam int ST_TACH    = 2;
	localparam int ST_EXT_A   = 3;
	localparam int ST_EXT_B   = 4;
	localparam logic [4:0] ST_THERMAL = 5'h01;

	localparam logic [7:0] RST_CFG        = 8'h18;
	localparam logic [7:0] RST_WINDOW     = 8'h08;
	localparam logic [7:0] RST_ALERT_MASK = 8'h1f;
	localparam logic [7:0] RST_TEMP_LIMIT = 8'h50;
	localparam logic [7:0] RST_PI_TARGET  = 8'h3c;
	localparam logic [7:0] RST_PI_GAIN    = 8'h04;
	localparam logic [7:0] RST_BOOST_TIME = 8'h0a;
	localparam logic [7:0] DUTY_FULL      = 8'hff;

	localparam logic [7:0] VID_BASE_TOP  = 8'hd0;
	localparam logic [7:0] VID_EXT_TOP   = 8'hd8;
	localparam logic [7:0] VID_LATER_TOP = 8'hc8;

	typedef enum logic [1:0] {
		HWMFC_VID_BASE  = 2'h0,
		HWMFC_VID_EXT   = 2'h1,
		HWMFC_VID_LATER = 2'h2
	} hwmfc_scheme_e;

	typedef struct packed {
		logic [N_TEMP-1:0][11:0] temp;
		logic [N_VOLT-1:0][7:0]  volt;
		logic                    sample;
	} hwmfc_sense_s;

	function automatic logic [7:0] hwmfc_sat8(input logic signed [11:0] v);
		if (v < 12'sh000) begin
			return 8'h00;
		end else if (v > 12'sh0ff) begin
			return 8'hff;
		end
		return v[7:0];
	endfunction

	function automatic logic [7:0] hwmfc_vid_decode(input logic [1:0] sch, input logic [6:0] voltage_identification_inputs);
		case (sch)
			HWMFC_VID_BASE:  return VID_BASE_TOP - {2'h0, voltage_identification_inputs[5:0]};
			HWMFC_VID_EXT:   return VID_EXT_TOP - {1'h0, voltage_identification_inputs[6:0]};
			HWMFC_VID_LATER: return (voltage_identification_inputs == 7'h00) ? 8'h00 : VID_LATER_TOP - {2'h0, voltage_identification_inputs[6:1]};
			default:         return 8'h00;
		endcase
	endfunction

endpackage

// >>> test_hw_monitor_fan_control_core.sv
`timescale 1ns/1ps
module test_hw_monitor_fan_control_core;
	import hwmfc_pkg::*;
	logic         ref_clk_i;
	logic         rst_n_i;
	logic   [7:0] reg_addr;
	logic   [7:0] reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic   [7:0] reg_rdata;
	hwmfc_sense_s sense;
	logic   [6:0] voltage_identification_inputs;
	logic         ext_a;
	logic         ext_b;
	logic   [3:0] tach;
	logic   [1:0] pwm_oe;
	logic         alert_oe;
	int           n_checks;
	int           n_mismatch;

	hwmfc_core #(.BOOST_TICK(8), .LUT_DEPTH(16)) i_hwmfc_core (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .sense_i(sense), .voltage_identification_inputs_i(voltage_identification_inputs),
		.ext_error_input_a_i(ext_a), .ext_error_input_b_i(ext_b), .tach_err_i(tach),
		.pwm_oe_o(pwm_oe), .alert_oe_o(alert_oe));
	hwmfc_host_model i_hwmfc_host_model (
		.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_hwmfc_host_model.wr(a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
			input string nm);
		logic [7:0] d;
		i_hwmfc_host_model.rd(a, d);
		chkv(nm, {8'h00, e}, {8'h00, d & m});
	endtask

	task automatic clr();
		wr(ADDR_HOST_STAT, 8'h1f);
		wr(ADDR_MGMT_STAT, 8'h1f);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			sense.sample <= 1'b1;
			@(posedge ref_clk_i);
			sense.sample <= 1'b0;
		end
	endtask

	task automatic wait_alert(input logic v);
		for (int i = 0; i < 16 && alert_oe !== v; i++) begin
			@(negedge ref_clk_i);
		end
		chkv("alert", {15'h0000, v}, {15'h0000, alert_oe});
		if (alert_oe !== v) begin
			test_done();
		end
	endtask

	task automatic sc_reset_regs();
		rdc(ADDR_CFG, 8'hff, RST_CFG, "cfg reset");
		rdc(ADDR_WINDOW, 8'hff, RST_WINDOW, "window reset");
		rdc(ADDR_ALERT_MASK, 8'hff, RST_ALERT_MASK, "mask reset");
		rdc(ADDR_TEMP_LIMIT, 8'hff, RST_TEMP_LIMIT, "limit reset");
		rdc(ADDR_PI_TARGET, 8'hff, RST_PI_TARGET, "target reset");
		rdc(ADDR_PI_GAIN, 8'hff, RST_PI_GAIN, "gain reset");
		rdc(ADDR_BOOST_TIME, 8'hff, RST_BOOST_TIME, "boost time reset");
		wr(ADDR_VID_EXPECT, 8'h00);
		rdc(ADDR_VID_EXPECT, 8'hff, VID_BASE_TOP - 8'h25, "expect read only");
		rdc(8'hff, 8'hff, 8'h00, "unmapped");
	endtask

	task automatic sc_setup();
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_LUT_BASE + 8'(i), (i == 1) ? 8'h80 : 8'h00);
		end
		wr(ADDR_ALERT_MASK, 8'h00);
		pulse(40);
		clr();
	endtask

	task automatic sc_pwm();
		logic [15:0] n;
		n = 16'h0000;
		rdc(ADDR_PWM1_DUTY, 8'hff, 8'h80, "fan 1 duty");
		rdc(ADDR_PWM2_DUTY, 8'hff, 8'h80, "fan 2 duty");
		repeat (1020) begin
			@(negedge ref_clk_i);
			n = n + ((pwm_oe[0] === 1'b0) ? 16'h0001 : 16'h0000);
		end
		chkv("fan 1 release cycles", 16'h0200, n);
	endtask

	task automatic sc_boost();
		@(posedge ref_clk_i);
		tach <= 4'h1;
		cyc(4);
		tach <= 4'h0;
		rdc(ADDR_PWM1_DUTY, 8'hff, DUTY_FULL, "boost duty");
		cyc(40);
		rdc(ADDR_PWM1_DUTY, 8'hff, DUTY_FULL, "boost hold");
		cyc(120);
		rdc(ADDR_PWM1_DUTY, 8'hff, 8'h80, "boost released");
		wr(ADDR_CFG, 8'h08);
		tach <= 4'h2;
		cyc(4);
		rdc(ADDR_PWM2_DUTY, 8'hff, 8'h80, "fan 2 boost off");
		rdc(ADDR_PWM1_DUTY, 8'hff, DUTY_FULL, "fan 1 boost on");
		tach <= 4'h0;
		cyc(160);
		wr(ADDR_CFG, RST_CFG);
		clr();
	endtask

	task automatic sc_status();
		wr(ADDR_ALERT_MASK, 8'h1f);
		wait_alert(1'b0);
		ext_a <= 1'b1;
		cyc(3);
		ext_a <= 1'b0;
		wait_alert(1'b1);
		rdc(ADDR_MGMT_STAT, 8'h1f, 8'h01 << ST_EXT_A, "mgmt ext a");
		rdc(ADDR_HOST_STAT, 8'h1f, 8'h01 << ST_EXT_A, "host ext a");
		wr(ADDR_HOST_STAT, 8'h01 << ST_EXT_A);
		wait_alert(1'b0);
		rdc(ADDR_HOST_STAT, 8'h1f, 8'h00, "host cleared");
		rdc(ADDR_MGMT_STAT, 8'h1f, 8'h01 << ST_EXT_A, "mgmt kept");
		ext_b <= 1'b1;
		cyc(3);
		ext_b <= 1'b0;
		rdc(ADDR_MGMT_STAT, 8'h10, 8'h10, "ext b armed");
		wr(ADDR_CFG, 8'h19);
		clr();
		ext_b <= 1'b1;
		cyc(4);
		rdc(ADDR_MGMT_STAT, 8'h18, 8'h00, "ext b ignored");
		ext_b <= 1'b0;
		wr(ADDR_CFG, RST_CFG);
		clr();
	endtask

	task automatic sc_cmp();
		wr(ADDR_ALERT_MASK, 8'h1f);
		wr(ADDR_CFG, 8'h1c);
		ext_a <= 1'b1;
		cyc(4);
		@(negedge ref_clk_i);
		chkv("alert nonthermal", 16'h0000, {15'h0000, alert_oe});
		@(posedge ref_clk_i);
		ext_a <= 1'b0;
		wr(ADDR_ALERT_MASK, 8'h1f);
		sense.temp[3] <= 12'h5a0;
		pulse(1);
		wait_alert(1'b1);
		sense.temp[3] <= 12'h0a0;
		pulse(1);
		wait_alert(1'b0);
		wr(ADDR_ALERT_MASK, 8'h00);
		wr(ADDR_CFG, RST_CFG);
		clr();
	endtask

	task automatic sc_vid();
		logic [7:0] e;
		for (int s = 0; s < 3; s++) begin
			e = (s == 0) ? VID_BASE_TOP - 8'h25 : (s == 1) ? VID_EXT_TOP - 8'h25
				: VID_LATER_TOP - 8'h12;
			wr(ADDR_CFG, RST_CFG | 8'(s));
			rdc(ADDR_VID_EXPECT, 8'hff, e, "expected level");
			sense.volt[0] <= e;
			pulse(2);
			clr();
			cyc(4);
			rdc(ADDR_MGMT_STAT, 8'h02, 8'h00, "window inside");
			sense.volt[0] <= e - 8'h40;
			pulse(2);
			cyc(4);
			rdc(ADDR_MGMT_STAT, 8'h02, 8'h02, "window fault");
		end
		wr(ADDR_CFG, RST_CFG);
		sense.volt[0] <= VID_BASE_TOP - 8'h25;
		pulse(2);
		clr();
	endtask

	task automatic sc_format();
		sense.temp[2] <= 12'hda8;
		sense.temp[4] <= 12'h190;
		sense.volt[1] <= 8'hc0;
		sense.volt[8] <= 8'h40;
		pulse(40);
		rdc(ADDR_TEMP_BASE + 8'h05, 8'hff, 8'hda, "raw msb");
		rdc(ADDR_TEMP_BASE + 8'h04, 8'h80, 8'h80, "raw lsb");
		rdc(ADDR_INT_TEMP + 8'h01, 8'hff, 8'h19, "internal msb");
		rdc(ADDR_INT_TEMP, 8'h80, 8'h00, "internal lsb");
		rdc(ADDR_FILT_BASE + 8'h05, 8'hff, 8'hda, "filtered msb");
		rdc(ADDR_FILT_BASE + 8'h04, 8'hf0, 8'h80, "filtered lsb");
		rdc(ADDR_VOLT_BASE + 8'h01, 8'hff, 8'hc0, "positive rail");
		rdc(ADDR_VOLT_BASE + 8'h08, 8'hff, 8'h40, "negative rail");
	endtask

	initial begin
		n_checks   = 0;
		n_mismatch = 0;
		rst_n_i    = 1'b0;
		voltage_identification_inputs        = 7'h25;
		ext_a      = 1'b0;
		ext_b      = 1'b0;
		tach       = 4'h0;
		sense      = '0;
		for (int i = 0; i < N_TEMP; i++) begin
			sense.temp[i] = 12'h0a0;
		end
		sense.volt[0] = VID_BASE_TOP - 8'h25;
		cyc(20);
		rst_n_i <= 1'b1;
		sc_reset_regs();
		sc_setup();
		sc_pwm();
		sc_boost();
		sc_status();
		sc_cmp();
		sc_vid();
		sc_format();
		test_done();
	end
endmodule
